// ==== core/uilf_map.svh ====
// Purpose: Offsets, field positions, reset values and codes for the interrupt id and line format block
// Assumes: Byte addresses on a 32-bit APB, one aligned word per register
// Notes: Included by bare name
`ifndef UILF_MAP_SVH
`define UILF_MAP_SVH

`define UILF_OFS_IID 8'h00
`define UILF_OFS_LFC 8'h04
`define UILF_OFS_FSC 8'h08
`define UILF_OFS_SRCEN 8'h0c
`define UILF_OFS_EVST 8'h10
`define UILF_OFS_EVMASK 8'h14
`define UILF_OFS_FMT 8'h18

`define UILF_LFC_DLAB 7
`define UILF_LFC_BREAK 6
`define UILF_LFC_STOP 2
`define UILF_FSC_ENABLE 0
`define UILF_FSC_RXRST 1
`define UILF_FSC_TXRST 2
`define UILF_FSC_DMA 3

`define UILF_SRC_RXDATA 0
`define UILF_SRC_THR 1
`define UILF_SRC_LINE 2
`define UILF_SRC_MODEM 3

`define UILF_LFC_RESET 8'h00
`define UILF_FSC_RESET 8'h00
`define UILF_SRCEN_RESET 4'h0
`define UILF_EV_RESET 5'h00

`define UILF_IID_LINE 4'h6
`define UILF_IID_RXDATA 4'h4
`define UILF_IID_TIMEOUT 4'hc
`define UILF_IID_THR 4'h2
`define UILF_IID_MODEM 4'h0
`define UILF_IID_NONE 4'h1

`define UILF_TRIG_0 5'h01
`define UILF_TRIG_1 5'h04
`define UILF_TRIG_2 5'h08
`define UILF_TRIG_3 5'h0e

`define UILF_WORD_BASE 4'h5
`define UILF_STOP_ONE 3'h2
`define UILF_STOP_ONEHALF 3'h3
`define UILF_STOP_TWO 3'h4

`endif

// ==== core/uilf_pkg.sv ====
// Purpose: Types shared by the interrupt id and line format block
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Numeric constants live in uilf_map.svh
package uilf_pkg;

  typedef enum logic [2:0] {
    UILF_PAR_NONE = 3'b000,
    UILF_PAR_ODD = 3'b001,
    UILF_PAR_EVEN = 3'b010,
    UILF_PAR_FORCE1 = 3'b011,
    UILF_PAR_FORCE0 = 3'b100
  } uilf_parity_e;

  typedef struct packed {
    logic [3:0] word_bits;
    logic [2:0] stop_halves;
    uilf_parity_e parity;
  } uilf_fmt_s;

  typedef struct packed {
    logic line;
    logic rxdata;
    logic timeout;
    logic thr;
    logic modem;
  } uilf_src_s;

endpackage

// ==== core/uilf_top.sv ====
// Purpose: Prioritized interrupt identification and serial line format control for one channel
// Assumes: Source conditions and TXD_IN come from logic on CORE_CLK_IN; APB master follows the bus rules
// Notes: APB answers with one wait state; every output is registered
// Contract
// RULE_01: Identification read returns highest pending source code
// RULE_02: Top source shown until serviced, then next
// RULE_03: Line status is level 1, code 0110
// RULE_04: Received data is level 2, code 0100
// RULE_05: Receive time-out is level 2, code 1100
// RULE_06: Transmit holding empty is level 3, code 0010
// RULE_07: Modem status change is level 4, code 0000
// RULE_08: Bit 0 low when pending, high otherwise
// RULE_09: Bits 7:6 ones when FIFOs enabled, else zero
// RULE_10: Format bit 7 redirects access to divisor latch
// RULE_11: Format bit 6 holds transmit output low
// RULE_12: Format bits 5:3 select parity mode
// RULE_13: Bit 2 selects one, one-half or two stops
// RULE_14: Bits 1:0 select five to eight data bits
// RULE_15: Reset format is 5 bits, 1 stop, no parity
// RULE_16: FIFO data interrupt at trigger count reached
// RULE_17: FIFO setup bits programmed only with enable set
// RULE_18: Parity code 101 forces a one parity bit
// RULE_19: Each source cleared by its customary service access
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "uilf_map.svh"

module uilf_top import uilf_pkg::*; #(
  parameter int RX_COUNT_W = 5,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic LINE_COND_IN,
  input wire logic RX_DATA_READY_IN,
  input wire logic [RX_COUNT_W-1:0] RX_COUNT_IN,
  input wire logic RX_TIMEOUT_IN,
  input wire logic THR_EMPTY_IN,
  input wire logic THR_WRITE_IN,
  input wire logic MODEM_CHANGE_IN,
  input wire logic TXD_IN,
  output logic TXD_OUT,
  output var uilf_fmt_s FORMAT_OUT,
  output logic DIVISOR_ACCESS_OUT,
  output logic FIFO_ENABLE_OUT,
  output logic DMA_MODE_OUT,
  output logic RX_FIFO_RESET_OUT,
  output logic TX_FIFO_RESET_OUT,
  output logic IRQ_OUT
);

  generate
    if (FIFO_DEPTH < 14 || (1 << RX_COUNT_W) <= FIFO_DEPTH) begin : g_bad_param
      $error("uilf_top: FIFO_DEPTH must reach 14 and fit RX_COUNT_W");
    end
  endgenerate

  logic [7:0] line_format_control;
  logic [7:0] fifo_setup_control;
  logic [3:0] source_enable;
  logic [4:0] event_status;
  logic [4:0] event_mask;
  logic [4:0] event_prev;
  logic thr_pend;
  logic thr_empty_q;

  // APB decode; access phase is two cycles since PREADY is a flop
  wire capture = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
  wire done = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire wr = done & PWRITE_IN;
  wire rd = done & ~PWRITE_IN;
  wire hit_iid = PADDR_IN == `UILF_OFS_IID;
  wire hit_lfc = PADDR_IN == `UILF_OFS_LFC;
  wire hit_fsc = PADDR_IN == `UILF_OFS_FSC;
  wire hit_srcen = PADDR_IN == `UILF_OFS_SRCEN;
  wire hit_evst = PADDR_IN == `UILF_OFS_EVST;
  wire hit_evmask = PADDR_IN == `UILF_OFS_EVMASK;
  wire hit_fmt = PADDR_IN == `UILF_OFS_FMT;
  wire mapped = hit_iid | hit_lfc | hit_fsc | hit_srcen | hit_evst | hit_evmask | hit_fmt;
  wire iid_readonly_write = PWRITE_IN & (hit_iid | hit_fmt);

  // Source conditions
  wire fifo_en = fifo_setup_control[`UILF_FSC_ENABLE];
  wire [1:0] trig_sel = fifo_setup_control[7:6];
  wire [4:0] trig_level = (trig_sel == 2'b00) ? `UILF_TRIG_0 :
                          (trig_sel == 2'b01) ? `UILF_TRIG_1 :
                          (trig_sel == 2'b10) ? `UILF_TRIG_2 : `UILF_TRIG_3;
  wire [RX_COUNT_W-1:0] trig_wide = RX_COUNT_W'(trig_level);
  wire rx_avail = fifo_en ? (RX_COUNT_IN >= trig_wide) : RX_DATA_READY_IN; // see RULE_16
  uilf_src_s pend;
  assign pend.line = LINE_COND_IN & source_enable[`UILF_SRC_LINE];
  assign pend.rxdata = rx_avail & source_enable[`UILF_SRC_RXDATA];
  assign pend.timeout = RX_TIMEOUT_IN & fifo_en & source_enable[`UILF_SRC_RXDATA];
  assign pend.thr = thr_pend & source_enable[`UILF_SRC_THR];
  assign pend.modem = MODEM_CHANGE_IN & source_enable[`UILF_SRC_MODEM];

  // Fixed priority; a lower source is only reported once the higher one drops
  wire [3:0] iid_code = pend.line ? `UILF_IID_LINE : // see RULE_01 see RULE_02 see RULE_03
                        pend.timeout ? `UILF_IID_TIMEOUT : // see RULE_05
                        pend.rxdata ? `UILF_IID_RXDATA : // see RULE_04
                        pend.thr ? `UILF_IID_THR : // see RULE_06
                        pend.modem ? `UILF_IID_MODEM : `UILF_IID_NONE; // see RULE_07 see RULE_08
  wire [7:0] iid_value = {fifo_en, fifo_en, 2'b00, iid_code}; // see RULE_09

  // Line format decode
  wire [5:3] par_sel = line_format_control[5:3];
  uilf_parity_e par_mode;
  assign par_mode = !par_sel[3] ? UILF_PAR_NONE : // see RULE_12
                    (par_sel == 3'b001) ? UILF_PAR_ODD :
                    (par_sel == 3'b011) ? UILF_PAR_EVEN :
                    (par_sel == 3'b101) ? UILF_PAR_FORCE1 : UILF_PAR_FORCE0; // see RULE_18
  wire [1:0] wl_code = line_format_control[1:0];
  uilf_fmt_s next_format;
  assign next_format.word_bits = `UILF_WORD_BASE + {2'b00, wl_code}; // see RULE_14
  assign next_format.stop_halves = !line_format_control[`UILF_LFC_STOP] ? `UILF_STOP_ONE : // see RULE_13
                                   (wl_code == 2'b00) ? `UILF_STOP_ONEHALF : `UILF_STOP_TWO;
  assign next_format.parity = par_mode;

  wire [31:0] read_value = hit_iid ? {24'h000000, iid_value} :
                           hit_lfc ? {24'h000000, line_format_control} :
                           hit_fsc ? {24'h000000, fifo_setup_control} :
                           hit_srcen ? {28'h0000000, source_enable} :
                           hit_evst ? {27'h0, event_status} :
                           hit_evmask ? {27'h0, event_mask} :
                           hit_fmt ? {22'h0, next_format} : 32'h00000000;

  // Holding-empty pending: edge set, cleared by a data write or by reading it as the reported id
  wire thr_rise = THR_EMPTY_IN & ~thr_empty_q;
  wire iid_read_thr = rd & hit_iid & (PRDATA_OUT[3:0] == `UILF_IID_THR);
  wire next_thr_pend = thr_rise | (thr_pend & ~(THR_WRITE_IN | iid_read_thr)); // see RULE_19

  // FIFO setup: with enable clear only the enable drops, other bits keep their value
  wire [7:0] fsc_wr = PWDATA_IN[`UILF_FSC_ENABLE] ? {PWDATA_IN[7:6], 2'b00, PWDATA_IN[3], 3'b001} :
                      {fifo_setup_control[7:1], 1'b0}; // see RULE_17
  wire fsc_write = wr & hit_fsc;
  wire next_rx_rst = fsc_write & PWDATA_IN[`UILF_FSC_ENABLE] & PWDATA_IN[`UILF_FSC_RXRST];
  wire next_tx_rst = fsc_write & PWDATA_IN[`UILF_FSC_ENABLE] & PWDATA_IN[`UILF_FSC_TXRST];

  wire [4:0] ev_now = pend;
  wire [4:0] ev_rise = ev_now & ~event_prev;
  wire [4:0] ev_clear = (wr & hit_evst) ? PWDATA_IN[4:0] : 5'h00;
  logic [4:0] next_event_status;

  // Set wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_event
      assign next_event_status[gi] = ev_rise[gi] | (event_status[gi] & ~ev_clear[gi]);
    end
  endgenerate

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= capture;
      PRDATA_OUT <= (capture & ~PWRITE_IN) ? read_value : PRDATA_OUT;
      PSLVERR_OUT <= capture & (~mapped | iid_readonly_write);
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      line_format_control <= `UILF_LFC_RESET; // see RULE_15
      fifo_setup_control <= `UILF_FSC_RESET;
      source_enable <= `UILF_SRCEN_RESET;
      event_mask <= `UILF_EV_RESET;
    end else begin
      line_format_control <= (wr & hit_lfc) ? PWDATA_IN[7:0] : line_format_control;
      fifo_setup_control <= fsc_write ? fsc_wr : fifo_setup_control;
      source_enable <= (wr & hit_srcen) ? PWDATA_IN[3:0] : source_enable;
      event_mask <= (wr & hit_evmask) ? PWDATA_IN[4:0] : event_mask;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      thr_pend <= 1'b0;
      thr_empty_q <= 1'b0;
      event_status <= `UILF_EV_RESET;
      event_prev <= `UILF_EV_RESET;
      IRQ_OUT <= 1'b0;
    end else begin
      thr_pend <= next_thr_pend;
      thr_empty_q <= THR_EMPTY_IN;
      event_status <= next_event_status;
      event_prev <= ev_now;
      IRQ_OUT <= |(next_event_status & event_mask);
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      TXD_OUT <= 1'b1;
      FORMAT_OUT <= '{word_bits: `UILF_WORD_BASE, stop_halves: `UILF_STOP_ONE, parity: UILF_PAR_NONE};
      DIVISOR_ACCESS_OUT <= 1'b0;
      FIFO_ENABLE_OUT <= 1'b0;
      DMA_MODE_OUT <= 1'b0;
      RX_FIFO_RESET_OUT <= 1'b0;
      TX_FIFO_RESET_OUT <= 1'b0;
    end else begin
      // Break overrides whatever the serializer drives
      TXD_OUT <= line_format_control[`UILF_LFC_BREAK] ? 1'b0 : TXD_IN; // see RULE_11
      FORMAT_OUT <= next_format;
      DIVISOR_ACCESS_OUT <= line_format_control[`UILF_LFC_DLAB]; // see RULE_10
      FIFO_ENABLE_OUT <= fifo_en;
      DMA_MODE_OUT <= fifo_setup_control[`UILF_FSC_DMA];
      RX_FIFO_RESET_OUT <= next_rx_rst;
      TX_FIFO_RESET_OUT <= next_tx_rst;
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_iid_capture;
    capture & ~PWRITE_IN & hit_iid;
  endsequence

  property p_iid_line;
    s_iid_capture and pend.line |=> PRDATA_OUT[3:0] == 4'h6;
  endproperty
  a_iid_line: assert property (p_iid_line) else $error("line status id wrong"); // see RULE_03

  property p_iid_rxdata;
    s_iid_capture and pend.rxdata & ~pend.line & ~pend.timeout |=> PRDATA_OUT[3:0] == 4'h4;
  endproperty
  a_iid_rxdata: assert property (p_iid_rxdata) else $error("data ready id wrong"); // see RULE_04

  property p_iid_timeout;
    s_iid_capture and pend.timeout & ~pend.line |=> PRDATA_OUT[3:0] == 4'hc;
  endproperty
  a_iid_timeout: assert property (p_iid_timeout) else $error("time-out id wrong"); // see RULE_05

  property p_iid_thr;
    s_iid_capture and pend.thr & ~pend.line & ~pend.rxdata & ~pend.timeout |=> PRDATA_OUT[3:0] == 4'h2;
  endproperty
  a_iid_thr: assert property (p_iid_thr) else $error("holding empty id wrong"); // see RULE_06

  property p_iid_modem;
    s_iid_capture and (pend == 5'b00001) |=> PRDATA_OUT[3:0] == 4'h0;
  endproperty
  a_iid_modem: assert property (p_iid_modem) else $error("modem id wrong"); // see RULE_07

  property p_iid_none;
    s_iid_capture and (pend == 5'b00000) |=> PRDATA_OUT[0] && PRDATA_OUT[3:1] == 3'b000;
  endproperty
  a_iid_none: assert property (p_iid_none) else $error("idle id bit 0 not high"); // see RULE_08

  property p_iid_fifo_bits;
    s_iid_capture |=> PRDATA_OUT[7:6] == {2{$past(fifo_en)}} && PRDATA_OUT[5:4] == 2'b00;
  endproperty
  a_iid_fifo_bits: assert property (p_iid_fifo_bits) else $error("FIFO bits wrong"); // see RULE_09

  property p_break;
    line_format_control[6] |=> !TXD_OUT;
  endproperty
  a_break: assert property (p_break) else $error("break not held low"); // see RULE_11

  property p_break_release;
    $fell(line_format_control[6]) |=> TXD_OUT == $past(TXD_IN);
  endproperty
  a_break_release: assert property (p_break_release) else $error("break not released"); // see RULE_11

  property p_dlab;
    line_format_control[7] |=> DIVISOR_ACCESS_OUT;
  endproperty
  a_dlab: assert property (p_dlab) else $error("divisor access not shown"); // see RULE_10

  property p_word_bits;
    ##1 FORMAT_OUT.word_bits == 4'h5 + {2'b00, $past(line_format_control[1:0])};
  endproperty
  a_word_bits: assert property (p_word_bits) else $error("word length wrong"); // see RULE_14

  property p_stop_half;
    line_format_control[2] && line_format_control[1:0] == 2'b00 |=> FORMAT_OUT.stop_halves == 3'h3;
  endproperty
  a_stop_half: assert property (p_stop_half) else $error("stop length wrong"); // see RULE_13

  property p_force_one;
    line_format_control[5:3] == 3'b101 |=> FORMAT_OUT.parity == UILF_PAR_FORCE1;
  endproperty
  a_force_one: assert property (p_force_one) else $error("forced one parity wrong"); // see RULE_18

  property p_fsc_gate;
    wr && hit_fsc && !PWDATA_IN[0] |=> fifo_setup_control[7:1] == $past(fifo_setup_control[7:1]) && !fifo_en;
  endproperty
  a_fsc_gate: assert property (p_fsc_gate) else $error("FIFO setup taken without enable"); // see RULE_17

  property p_thr_clear;
    THR_WRITE_IN && !thr_rise |=> !thr_pend;
  endproperty
  a_thr_clear: assert property (p_thr_clear) else $error("holding empty not cleared"); // see RULE_19

  property p_par_none;
    !line_format_control[3] |=> FORMAT_OUT.parity == UILF_PAR_NONE;
  endproperty
  a_par_none: assert property (p_par_none) else $error("no parity not shown"); // see RULE_12

  property p_par_odd;
    line_format_control[5:3] == 3'b001 |=> FORMAT_OUT.parity == UILF_PAR_ODD;
  endproperty
  a_par_odd: assert property (p_par_odd) else $error("odd parity not shown"); // see RULE_12

  property p_par_even;
    line_format_control[5:3] == 3'b011 |=> FORMAT_OUT.parity == UILF_PAR_EVEN;
  endproperty
  a_par_even: assert property (p_par_even) else $error("even parity not shown"); // see RULE_12

  property p_stop_one;
    !line_format_control[2] |=> FORMAT_OUT.stop_halves == 3'h2;
  endproperty
  a_stop_one: assert property (p_stop_one) else $error("single stop not shown"); // see RULE_13

  property p_stop_two;
    line_format_control[2] && line_format_control[1:0] != 2'b00 |=> FORMAT_OUT.stop_halves == 3'h4;
  endproperty
  a_stop_two: assert property (p_stop_two) else $error("two stops not shown"); // see RULE_13

  property p_dlab_clear;
    !line_format_control[7] |=> !DIVISOR_ACCESS_OUT;
  endproperty
  a_dlab_clear: assert property (p_dlab_clear) else $error("divisor access not released"); // see RULE_10

  // Reset pulses last one cycle, so a FIFO is never held in reset across transfers
  sequence s_fsc_enable_write;
    wr & hit_fsc & PWDATA_IN[`UILF_FSC_ENABLE];
  endsequence

  property p_rx_rst_pulse;
    s_fsc_enable_write and PWDATA_IN[`UILF_FSC_RXRST] |=> RX_FIFO_RESET_OUT ##1 !RX_FIFO_RESET_OUT;
  endproperty
  a_rx_rst_pulse: assert property (p_rx_rst_pulse) else $error("receive reset pulse wrong"); // see RULE_17

  property p_tx_rst_pulse;
    s_fsc_enable_write and PWDATA_IN[`UILF_FSC_TXRST] |=> TX_FIFO_RESET_OUT ##1 !TX_FIFO_RESET_OUT;
  endproperty
  a_tx_rst_pulse: assert property (p_tx_rst_pulse) else $error("transmit reset pulse wrong"); // see RULE_17

  property p_fsc_no_rst;
    wr && hit_fsc && !PWDATA_IN[0] |=> !RX_FIFO_RESET_OUT && !TX_FIFO_RESET_OUT;
  endproperty
  a_fsc_no_rst: assert property (p_fsc_no_rst) else $error("FIFO reset without enable"); // see RULE_17

endmodule
`default_nettype wire

// ==== tb/uilf_host.sv ====
// Purpose: APB host model standing in for the processor on the parallel bus
// Assumes: Callers enter xfer just after a rising clock edge
// Notes: Waits for pready with no bound of its own, the bench watchdog ends a hung wait; one idle edge follows
`timescale 1ns/1ns
`default_nettype none
module uilf_host (
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out
);
  initial begin
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwrite_out <= 1'b0;
    paddr_out <= 8'h00;
    pwdata_out <= 32'h00000000;
  end
  // Register accesses (reads, writes) are issued through this task; the bench pulses holding writes directly
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // Idle edge so a following setup never lands in the same time step
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ==== tb/uilf_top_bench.sv ====
// Purpose: Self-checking bench for the interrupt id and line format block
// Assumes: Source inputs change right after a rising edge
// Notes: Format codes run from a table; priority, FIFO, irq and break cases follow
`timescale 1ns/1ns
`default_nettype none
`include "uilf_map.svh"
module uilf_top_bench import uilf_pkg::*;;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, line, rxd, tmo, the, thw, mdm, txi, txo;
  logic dlab, fen, dma, rxr, txr, irq, rerr;
  logic [7:0] paddr;
  logic [4:0] cnt;
  logic [31:0] pwdata, prdata, rdat;
  logic [17:0] rows [11];
  uilf_fmt_s fmt;
  int errors, tests_run, rxr_n, txr_n;

  uilf_top DUT (.CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LINE_COND_IN(line), .RX_DATA_READY_IN(rxd),
    .RX_COUNT_IN(cnt), .RX_TIMEOUT_IN(tmo), .THR_EMPTY_IN(the), .THR_WRITE_IN(thw),
    .MODEM_CHANGE_IN(mdm), .TXD_IN(txi), .TXD_OUT(txo), .FORMAT_OUT(fmt),
    .DIVISOR_ACCESS_OUT(dlab), .FIFO_ENABLE_OUT(fen), .DMA_MODE_OUT(dma),
    .RX_FIFO_RESET_OUT(rxr), .TX_FIFO_RESET_OUT(txr), .IRQ_OUT(irq));
  uilf_host HOST (.clk_in(clk), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata));

  function automatic logic [9:0] fm(input int w, input int s, input int p);
    return {w[3:0], s[2:0], p[2:0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    HOST.xfer(1'b1, a, d, rdat, rerr);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    HOST.xfer(1'b0, a, 32'h00000000, rdat, rerr);
    chk("read data", e, rdat);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task close_out;
    $display("Checks made %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Counted at the edge, so a one-cycle reset pulse is seen exactly once
  always @(posedge clk) begin
    if (rxr === 1'b1)
      rxr_n++;
    if (txr === 1'b1)
      txr_n++;
  end
  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #1000000;
    errors++;
    close_out;
  end

  initial begin
    {rst, line, rxd, tmo, the, thw, mdm} = 7'h40;
    cnt = 5'h00;
    txi = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`UILF_OFS_IID, 32'h00000001);
    rd(`UILF_OFS_LFC, 32'h00000000);
    chk("slave error", 32'h0, {31'h0, rerr});
    chk("format port", {22'h0, fm(5, 2, 0)}, {22'h0, fmt});
    chk("serial out", 32'h1, {31'h0, txo});
    $display("Test reset done");
    rows = '{{8'h00, fm(5, 2, 0)}, {8'h01, fm(6, 2, 0)}, {8'h02, fm(7, 2, 0)}, {8'h03, fm(8, 2, 0)},
      {8'h04, fm(5, 3, 0)}, {8'h07, fm(8, 4, 0)}, {8'h08, fm(5, 2, 1)}, {8'h18, fm(5, 2, 2)},
      {8'h28, fm(5, 2, 3)}, {8'h38, fm(5, 2, 4)}, {8'h30, fm(5, 2, 0)}};
    for (int i = 0; i < 11; i++) begin
      wr(`UILF_OFS_LFC, {24'h0, rows[i][17:10]});
      rd(`UILF_OFS_LFC, {24'h0, rows[i][17:10]});
      rd(`UILF_OFS_FMT, {22'h0, rows[i][9:0]});
      chk("format port", {22'h0, rows[i][9:0]}, {22'h0, fmt});
    end
    $display("Test format table done");
    wr(`UILF_OFS_SRCEN, 32'h0000000f);
    {line, rxd, the, mdm} <= 4'hf;
    idle(3);
    rd(`UILF_OFS_IID, 32'h00000006);
    line <= 1'b0;
    idle(3);
    rd(`UILF_OFS_IID, 32'h00000004);
    rxd <= 1'b0;
    idle(3);
    rd(`UILF_OFS_IID, 32'h00000002);
    rd(`UILF_OFS_IID, 32'h00000000);
    the <= 1'b0;
    mdm <= 1'b0;
    idle(2);
    the <= 1'b1;
    idle(3);
    rd(`UILF_OFS_IID, 32'h00000002);
    thw <= 1'b1;
    @(posedge clk);
    thw <= 1'b0;
    idle(3);
    rd(`UILF_OFS_IID, 32'h00000001);
    $display("Test priority done");
    wr(`UILF_OFS_FSC, 32'h00000001);
    tmo <= 1'b1;
    idle(3);
    rd(`UILF_OFS_IID, 32'h000000cc);
    tmo <= 1'b0;
    idle(3);
    rd(`UILF_OFS_IID, 32'h000000c1);
    cnt <= 5'h01;
    idle(3);
    rd(`UILF_OFS_IID, 32'h000000c4);
    wr(`UILF_OFS_FSC, 32'h000000c9);
    cnt <= 5'h0d;
    idle(3);
    rd(`UILF_OFS_IID, 32'h000000c1);
    chk("dma mode", 32'h1, {31'h0, dma});
    cnt <= 5'h0e;
    idle(3);
    rd(`UILF_OFS_IID, 32'h000000c4);
    wr(`UILF_OFS_FSC, 32'h00000006);
    rd(`UILF_OFS_FSC, 32'h000000c8);
    chk("fifo enable", 32'h0, {31'h0, fen});
    chk("rx fifo reset", 32'h0, rxr_n);
    chk("tx fifo reset", 32'h0, txr_n);
    wr(`UILF_OFS_FSC, 32'h00000007);
    idle(1);
    chk("rx fifo reset", 32'h1, rxr_n);
    chk("tx fifo reset", 32'h1, txr_n);
    rd(`UILF_OFS_FSC, 32'h00000001);
    wr(`UILF_OFS_FSC, 32'h00000000);
    rd(`UILF_OFS_IID, 32'h00000001);
    $display("Test fifo done");
    wr(`UILF_OFS_EVST, 32'h0000001f);
    wr(`UILF_OFS_EVMASK, 32'h00000010);
    line <= 1'b1;
    idle(3);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`UILF_OFS_EVST, 32'h00000010);
    wr(`UILF_OFS_EVMASK, 32'h00000000);
    idle(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`UILF_OFS_EVMASK, 32'h00000010);
    idle(2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`UILF_OFS_EVST, 32'h00000010);
    idle(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(`UILF_OFS_EVST, 32'h00000000);
    line <= 1'b0;
    $display("Test irq done");
    wr(`UILF_OFS_LFC, 32'h00000040);
    repeat (5) begin
      @(posedge clk);
      chk("break", 32'h0, {31'h0, txo});
    end
    wr(`UILF_OFS_LFC, 32'h00000080);
    idle(2);
    chk("serial out", 32'h1, {31'h0, txo});
    chk("divisor access", 32'h1, {31'h0, dlab});
    txi <= 1'b0;
    idle(2);
    chk("serial follow", 32'h0, {31'h0, txo});
    txi <= 1'b1;
    wr(`UILF_OFS_LFC, 32'h00000000);
    idle(1);
    chk("divisor access", 32'h0, {31'h0, dlab});
    $display("Test break done");
    rd(8'h1c, 32'h00000000);
    chk("slave error", 32'h1, {31'h0, rerr});
    wr(`UILF_OFS_IID, 32'h000000ff);
    chk("slave error", 32'h1, {31'h0, rerr});
    rd(`UILF_OFS_IID, 32'h00000001);
    $display("Test refusal done");
    close_out;
  end
endmodule
`default_nettype wire
